// *** core/shp_params.svh ***
// constants of the strobed host register port
`ifndef SHP_PARAMS_SVH
`define SHP_PARAMS_SVH

`define SHP_SEL_SETUP_A  3'h0
`define SHP_SEL_SETUP_B  3'h1
`define SHP_SEL_STATUS   3'h2
`define SHP_SEL_COMMAND  3'h3
`define SHP_SEL_SCAN_OUT 3'h4
`define SHP_SEL_SCAN_IN  3'h5
`define SHP_SEL_COUNT    3'h6
`define SHP_SEL_MANUAL   3'h7

`define SHP_RST_SETUP_A  8'h00
`define SHP_RST_SETUP_B  8'h80
`define SHP_RST_COMMAND  8'h00
`define SHP_RST_COUNT    8'h00
`define SHP_RST_MANUAL   8'h00
`define SHP_RST_BYTE     8'h00

`define SHP_STAT_SIN_EMPTY  7
`define SHP_STAT_SOUT_FULL  6
`define SHP_CMD_SOFT_RESET  7
`define SHP_CMD_OPCODE_MSB  3
`define SHP_SETUP_B_DELAY_MSB 3
`define SHP_MANUAL_MASK     8'h0F

`define SHP_LEAD_MAX        3'h4
`define SHP_BUF_DEPTH       4

`endif

// *** core/shp_pkg.sv ***
// types shared by the strobed host register port
package shp_pkg;
	typedef enum logic [2:0] {
		SHP_IDLE  = 3'b001,
		SHP_READ  = 3'b010,
		SHP_WRITE = 3'b100
	} shp_state_t;

	typedef struct packed {
		logic [7:0] setup_a;
		logic [7:0] setup_b;
		logic [7:0] command;
		logic [7:0] count;
		logic [7:0] manual;
	} shp_cfg_t;

	typedef struct packed {
		logic       counter_state_flag;
		logic [3:0] tap_state_field;
	} shp_core_stat_t;
endpackage

// *** core/shp_sync.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module shp_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] level_o
);
	logic [W-1:0] q1_r;
	logic [W-1:0] q2_r;
	logic [W-1:0] q3_r;
	logic [W-1:0] level_nxt;

	// level moves only once stages two and three agree
	always_comb begin
		level_nxt = (q2_r == q3_r) ? q3_r : level_o;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q1_r    <= RST;
			q2_r    <= RST;
			q3_r    <= RST;
			level_o <= RST;
		end else if (ce_i) begin
			q1_r    <= async_i;
			q2_r    <= q1_r;
			q3_r    <= q2_r;
			level_o <= level_nxt;
		end
	end
endmodule

// *** core/shp_fifo.sv ***
// small byte buffer with registered head
`timescale 1ns/1ps
module shp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         ce_i,
	input  wire logic         flush_i,
	input  wire logic         push_i,
	input  wire logic [W-1:0] push_data_i,
	input  wire logic         pop_i,
	output logic      [W-1:0] head_o,
	output logic              valid_o,
	output logic              full_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
			$error("shp_fifo: DEPTH must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] wr_ptr_nxt;
	logic [AW-1:0] rd_ptr_r;
	logic [AW-1:0] rd_ptr_nxt;
	logic [AW:0]   count_r;
	logic [AW:0]   count_nxt;
	logic [W-1:0]  head_nxt;
	logic          wr;
	logic          rd;

	always_comb begin
		wr = push_i && !full_o && !flush_i;
		rd = pop_i && (count_r != '0) && !flush_i;
		wr_ptr_nxt = wr ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = rd ? rd_ptr_r + 1'b1 : rd_ptr_r;
		count_nxt  = count_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
		if (flush_i) begin
			wr_ptr_nxt = '0;
			rd_ptr_nxt = '0;
			count_nxt  = '0;
		end
		// bypass keeps the head right when the slot is written now
		if (wr && wr_ptr_r == rd_ptr_nxt)
			head_nxt = push_data_i;
		else
			head_nxt = mem[rd_ptr_nxt];
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && wr)
			mem[wr_ptr_r] <= push_data_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			head_o   <= '0;
			valid_o  <= 1'b0;
			full_o   <= 1'b0;
		end else if (ce_i) begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
			head_o   <= head_nxt;
			valid_o  <= (count_nxt != '0);
			full_o   <= (count_nxt == DEPTH[AW:0]);
		end
	end
endmodule

// *** core/shp_host_port.sv ***
// strobed host register port of the scan controller
//
// What this block does
// - strobe alone times accesses; direction picks read
// - read enables data bus at strobe fall
// - data bus released whenever strobe is high
// - data bus never driven during a write
// - write captures bus at strobe rise
// - blocked access drops grant until it clears
// - empty scan-in read waits for data
// - full or flushing scan-out write waits
// - busy command holds setup, command, count writes
// - soft reset command write never held
// - retimed duplex writes lead reads by four
// - scan-in empty and scan-out full or flushing visible in status
// - all readable; status and scan-in read-only
// - other writes during command held or ignored, except scan-out
// - reserved read-only bits read zero
// - eight registers in fixed select order
// - setup registers writable unless command runs
`timescale 1ns/1ps
`include "shp_params.svh"
module shp_host_port #(
	parameter int BUF_DEPTH = `SHP_BUF_DEPTH
) (
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   ce_i,
	input  wire logic                   access_strobe_n_i,
	input  wire logic                   read_not_write_i,
	input  wire logic [2:0]             register_select_i,
	input  wire logic [7:0]             host_data_bus_i,
	output logic      [7:0]             host_data_bus_o,
	output logic                        host_data_bus_oe_o,
	output logic                        grant_o,
	output shp_pkg::shp_cfg_t           config_o,
	output logic                        soft_reset_o,
	input  wire logic                   cmd_done_i,
	input  wire shp_pkg::shp_core_stat_t core_stat_i,
	input  wire logic                   full_duplex_i,
	input  wire logic                   scan_out_flush_i,
	input  wire logic                   scan_out_pop_i,
	output logic      [7:0]             scan_out_data_o,
	output logic                        scan_out_valid_o,
	input  wire logic                   scan_in_push_i,
	input  wire logic [7:0]             scan_in_data_i,
	output logic                        scan_in_full_o
);
	import shp_pkg::*;

	logic       stb_lvl;
	logic       stb_prev_r;
	logic       rw_lvl;
	logic [2:0] sel_lvl;
	logic [7:0] data_lvl;

	shp_state_t state_r;
	shp_state_t state_nxt;
	logic       acc_rw_r;
	logic       acc_rw_nxt;
	logic [2:0] acc_sel_r;
	logic [2:0] acc_sel_nxt;
	logic       served_r;
	logic       served_nxt;
	logic       grant_nxt;
	logic       oe_nxt;
	logic [7:0] dout_nxt;
	shp_cfg_t   cfg_nxt;
	logic [7:0] sout_last_r;
	logic [7:0] sout_last_nxt;
	logic [2:0] lead_r;
	logic [2:0] lead_nxt;
	logic       sreset_nxt;

	logic       fall;
	logic       rise;
	logic       busy;
	logic       lead_block;
	logic       rd_blocked;
	logic       wr_blocked;
	logic       do_write;
	logic       sout_push;
	logic       sin_pop;
	logic       sin_valid;
	logic       sout_full;
	logic [7:0] sin_head;
	logic [7:0] status;
	logic [7:0] rd_mux;

	// all host pins cross into the core clock before use
	shp_sync #(.W(1), .RST(1'b1)) u_sync_stb (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.ce_i     (ce_i),
		.async_i  (access_strobe_n_i),
		.level_o  (stb_lvl)
	);
	shp_sync #(.W(12), .RST(12'h000)) u_sync_bus (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.ce_i     (ce_i),
		.async_i  ({read_not_write_i, register_select_i, host_data_bus_i}),
		.level_o  ({rw_lvl, sel_lvl, data_lvl})
	);

	shp_fifo #(.W(8), .DEPTH(BUF_DEPTH)) u_scan_out (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.ce_i        (ce_i),
		.flush_i     (scan_out_flush_i || sreset_nxt),
		.push_i      (sout_push),
		.push_data_i (data_lvl),
		.pop_i       (scan_out_pop_i),
		.head_o      (scan_out_data_o),
		.valid_o     (scan_out_valid_o),
		.full_o      (sout_full)
	);
	shp_fifo #(.W(8), .DEPTH(BUF_DEPTH)) u_scan_in (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.ce_i        (ce_i),
		.flush_i     (sreset_nxt),
		.push_i      (scan_in_push_i),
		.push_data_i (scan_in_data_i),
		.pop_i       (sin_pop),
		.head_o      (sin_head),
		.valid_o     (sin_valid),
		.full_o      (scan_in_full_o)
	);

	// blocking conditions and live status
	always_comb begin
		fall = stb_prev_r && !stb_lvl;
		rise = !stb_prev_r && stb_lvl;
		busy = (config_o.command[`SHP_CMD_OPCODE_MSB:0] != 4'h0);
		lead_block = full_duplex_i && (lead_r >= `SHP_LEAD_MAX) &&
			(config_o.setup_b[`SHP_SETUP_B_DELAY_MSB:0] != 4'h0);
		rd_blocked = (acc_sel_r == `SHP_SEL_SCAN_IN) && !sin_valid;
		case (acc_sel_r)
			`SHP_SEL_SCAN_OUT: wr_blocked = sout_full || scan_out_flush_i ||
				lead_block;
			`SHP_SEL_SETUP_A,
			`SHP_SEL_SETUP_B,
			`SHP_SEL_COUNT:    wr_blocked = busy;
			`SHP_SEL_COMMAND:  wr_blocked = busy &&
				!data_lvl[`SHP_CMD_SOFT_RESET];
			default:           wr_blocked = 1'b0;
		endcase
		// reserved read-only bit 4 reads zero
		status = {!sin_valid, sout_full || scan_out_flush_i,
			core_stat_i.counter_state_flag, 1'b0,
			core_stat_i.tap_state_field};
		case (acc_sel_r)
			`SHP_SEL_SETUP_A:  rd_mux = config_o.setup_a;
			`SHP_SEL_SETUP_B:  rd_mux = config_o.setup_b;
			`SHP_SEL_STATUS:   rd_mux = status;
			`SHP_SEL_COMMAND:  rd_mux = config_o.command;
			`SHP_SEL_SCAN_OUT: rd_mux = sout_last_r;
			`SHP_SEL_SCAN_IN:  rd_mux = sin_head;
			`SHP_SEL_COUNT:    rd_mux = config_o.count;
			default:           rd_mux = config_o.manual;
		endcase
	end

	// access sequencer
	always_comb begin
		state_nxt   = state_r;
		acc_rw_nxt  = acc_rw_r;
		acc_sel_nxt = acc_sel_r;
		served_nxt  = served_r;
		grant_nxt   = grant_o;
		oe_nxt      = host_data_bus_oe_o;
		dout_nxt    = host_data_bus_o;
		do_write    = 1'b0;
		sin_pop     = 1'b0;
		case (state_r)
			SHP_IDLE: begin
				grant_nxt = 1'b1;
				if (fall) begin
					acc_rw_nxt  = rw_lvl;
					acc_sel_nxt = sel_lvl;
					served_nxt  = 1'b0;
					oe_nxt      = rw_lvl;
					state_nxt   = rw_lvl ? SHP_READ : SHP_WRITE;
				end
			end
			SHP_READ: begin
				if (rise) begin
					// abort while held leaves the buffer untouched
					oe_nxt    = 1'b0;
					grant_nxt = 1'b1;
					state_nxt = SHP_IDLE;
				end else if (!served_r) begin
					if (rd_blocked) begin
						grant_nxt = 1'b0;
					end else begin
						dout_nxt   = rd_mux;
						grant_nxt  = 1'b1;
						served_nxt = 1'b1;
						sin_pop    = (acc_sel_r == `SHP_SEL_SCAN_IN);
					end
				end
			end
			SHP_WRITE: begin
				oe_nxt    = 1'b0;
				grant_nxt = !wr_blocked;
				if (rise) begin
					do_write  = !wr_blocked;
					grant_nxt = 1'b1;
					state_nxt = SHP_IDLE;
				end
			end
			default: begin
				state_nxt = SHP_IDLE;
				oe_nxt    = 1'b0;
				grant_nxt = 1'b1;
			end
		endcase
	end

	// register file and scan bookkeeping
	always_comb begin
		cfg_nxt       = config_o;
		sout_last_nxt = sout_last_r;
		sreset_nxt    = 1'b0;
		sout_push     = 1'b0;
		if (cmd_done_i)
			cfg_nxt.command[`SHP_CMD_OPCODE_MSB:0] = 4'h0;
		if (do_write) begin
			case (acc_sel_r)
				`SHP_SEL_SETUP_A:  cfg_nxt.setup_a = data_lvl;
				`SHP_SEL_SETUP_B:  cfg_nxt.setup_b = data_lvl;
				`SHP_SEL_COMMAND: begin
					if (data_lvl[`SHP_CMD_SOFT_RESET]) begin
						// soft reset self-clears and ends any command
						sreset_nxt      = 1'b1;
						cfg_nxt.command = `SHP_RST_COMMAND;
					end else begin
						cfg_nxt.command = data_lvl;
					end
				end
				`SHP_SEL_SCAN_OUT: begin
					sout_push     = 1'b1;
					sout_last_nxt = data_lvl;
				end
				`SHP_SEL_COUNT:    cfg_nxt.count = data_lvl;
				`SHP_SEL_MANUAL: begin
					// ignored, not held, while a command runs
					if (!busy)
						cfg_nxt.manual = data_lvl & `SHP_MANUAL_MASK;
				end
				default: ; // status and scan-in are read-only
			endcase
		end
		// floor at zero: bytes left from before the scan must not wrap it
		lead_nxt = lead_r + {2'b00, sout_push} -
			{2'b00, sin_pop && (lead_r != 3'h0)};
		if (!full_duplex_i || sreset_nxt ||
			config_o.setup_b[`SHP_SETUP_B_DELAY_MSB:0] == 4'h0)
			lead_nxt = 3'h0;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stb_prev_r         <= 1'b1;
			state_r            <= SHP_IDLE;
			acc_rw_r           <= 1'b0;
			acc_sel_r          <= 3'h0;
			served_r           <= 1'b0;
			grant_o            <= 1'b1;
			host_data_bus_oe_o <= 1'b0;
			host_data_bus_o    <= `SHP_RST_BYTE;
			config_o.setup_a   <= `SHP_RST_SETUP_A;
			config_o.setup_b   <= `SHP_RST_SETUP_B;
			config_o.command   <= `SHP_RST_COMMAND;
			config_o.count     <= `SHP_RST_COUNT;
			config_o.manual    <= `SHP_RST_MANUAL;
			sout_last_r        <= `SHP_RST_BYTE;
			lead_r             <= 3'h0;
			soft_reset_o       <= 1'b0;
		end else if (ce_i) begin
			stb_prev_r         <= stb_lvl;
			state_r            <= state_nxt;
			acc_rw_r           <= acc_rw_nxt;
			acc_sel_r          <= acc_sel_nxt;
			served_r           <= served_nxt;
			grant_o            <= grant_nxt;
			host_data_bus_oe_o <= oe_nxt;
			host_data_bus_o    <= dout_nxt;
			config_o           <= cfg_nxt;
			sout_last_r        <= sout_last_nxt;
			lead_r             <= lead_nxt;
			soft_reset_o       <= sreset_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i || !ce_i);

	chk_write_no_oe: assert property ((state_r == SHP_WRITE) |->
		!host_data_bus_oe_o) else $error("data bus driven during write");
	chk_read_oe_fall: assert property (fall && rw_lvl &&
		state_r == SHP_IDLE |=> host_data_bus_oe_o)
		else $error("read did not enable data bus");
	chk_oe_off_rise: assert property ((state_r == SHP_READ) && rise |=>
		!host_data_bus_oe_o && state_r == SHP_IDLE)
		else $error("data bus not released after strobe");
	chk_grant_idle: assert property ((state_r == SHP_IDLE) |->
		grant_o) else $error("grant low with no access");
	chk_sin_hold: assert property ((state_r == SHP_READ) && !rise &&
		!served_r && acc_sel_r == `SHP_SEL_SCAN_IN && !sin_valid |=>
		!grant_o) else $error("empty scan-in read not held");
	chk_sout_hold: assert property ((state_r == SHP_WRITE) && !rise &&
		acc_sel_r == `SHP_SEL_SCAN_OUT && sout_full |=> !grant_o)
		else $error("full scan-out write not held");
	chk_busy_hold: assert property ((state_r == SHP_WRITE) && !rise &&
		busy && acc_sel_r == `SHP_SEL_SETUP_A |=> !grant_o)
		else $error("setup write not held while busy");
	chk_srst_free: assert property ((state_r == SHP_WRITE) && !rise &&
		acc_sel_r == `SHP_SEL_COMMAND && data_lvl[`SHP_CMD_SOFT_RESET] |=>
		grant_o) else $error("soft reset write was held");
	chk_write_rise: assert property ((state_r == SHP_WRITE) && rise &&
		!wr_blocked && acc_sel_r == `SHP_SEL_COUNT |=>
		config_o.count == $past(data_lvl))
		else $error("count write not captured at strobe rise");
	chk_lead_cap: assert property (lead_r <= `SHP_LEAD_MAX)
		else $error("scan-out lead above limit");

	cov_read_done: cover property ((state_r == SHP_READ) && rise);
	cov_write_done: cover property ((state_r == SHP_WRITE) && rise &&
		!wr_blocked);
	cov_held_read: cover property (!grant_o && state_r == SHP_READ ##1
		grant_o);
	cov_soft_reset: cover property (soft_reset_o);
endmodule

// *** sim/shp_host_model.sv ***
// host processor model driving the strobed register port
`timescale 1ns/1ps
module shp_host_model (
	input  wire logic       clk_i,
	input  wire logic       grant_i,
	input  wire logic [7:0] bus_i,
	output logic            strobe_n_o,
	output logic            rnw_o,
	output logic [2:0]      sel_o,
	output logic [7:0]      data_o,
	output logic            data_oe_o,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	output logic            tout_o
);
	initial begin
		strobe_n_o = 1'b1;
		rnw_o = 1'b1;
		sel_o = 3'h0;
		data_o = 8'h00;
		data_oe_o = 1'b0;
		done_o = 1'b0;
		rdata_o = 8'h00;
		tout_o = 1'b0;
	end

	// abort ignores grant and lets go after a fixed time
	task automatic xfer(input logic rnw, input logic [2:0] sel,
		input logic [7:0] wd, input logic abort);
		int n;
		@(posedge clk_i);
		rnw_o <= rnw;
		sel_o <= sel;
		data_o <= wd;
		data_oe_o <= ~rnw;
		@(posedge clk_i);
		strobe_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		n = 0;
		if (abort)
			repeat (30) @(posedge clk_i);
		else
			while (grant_i !== 1'b1 && n < 300) begin
				@(posedge clk_i);
				n++;
			end
		if (n >= 300)
			tout_o <= 1'b1;
		rdata_o <= bus_i;
		done_o <= rnw & ~abort;
		strobe_n_o <= 1'b1;
		@(posedge clk_i);
		done_o <= 1'b0;
		// data held well past the rise so the sync filter sees it
		repeat (8) @(posedge clk_i);
		data_oe_o <= 1'b0;
	endtask
endmodule

// *** sim/tb_strobed_host_register_port.sv ***
// self-checking bench of the strobed host register port
`timescale 1ns/1ps
module tb_strobed_host_register_port;
	import shp_pkg::*;
	logic           clk_i;
	logic           resetn_i;
	logic           cmd_done;
	logic           pop;
	logic           push;
	logic           flush;
	logic           ce;
	logic           sin_full;
	logic           duplex;
	logic [7:0]     push_d;
	shp_core_stat_t cs;
	logic           h_stb_n;
	logic           h_rnw;
	logic [2:0]     h_sel;
	logic [7:0]     h_d;
	logic           h_oe;
	logic           h_done;
	logic [7:0]     h_rdata;
	logic           h_tout;
	logic [7:0]     d_d;
	logic           d_oe;
	logic           grant;
	shp_cfg_t       cfg;
	logic           sreset;
	logic [7:0]     so_data;
	logic           so_valid;
	logic [7:0]     bus;
	logic [7:0]     last = 8'hA5;
	logic [7:0]     v;
	logic [7:0]     man;
	logic [7:0]     b [0:5];
	logic [7:0]     wmask [0:7] = '{8'h2A, 8'hEF, 8'h00, 8'h70,
		8'h00, 8'h00, 8'hFF, 8'h0F};
	logic [7:0]     exp_q [$];
	string          name_q [$];
	int             num_errors;
	int             checks_done;
	int             hi_cnt;
	int             wr_cnt;
	int             sr_cnt;

	// undriven bus shows the inverse of its last level, not a fake hold
	assign bus = h_oe ? h_d : (d_oe ? d_d : ~last);

	shp_host_model host (.clk_i(clk_i), .grant_i(grant), .bus_i(bus),
		.strobe_n_o(h_stb_n), .rnw_o(h_rnw), .sel_o(h_sel), .data_o(h_d),
		.data_oe_o(h_oe), .done_o(h_done), .rdata_o(h_rdata),
		.tout_o(h_tout));

	shp_host_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
		.access_strobe_n_i(h_stb_n), .read_not_write_i(h_rnw),
		.register_select_i(h_sel), .host_data_bus_i(bus),
		.host_data_bus_o(d_d), .host_data_bus_oe_o(d_oe), .grant_o(grant),
		.config_o(cfg), .soft_reset_o(sreset), .cmd_done_i(cmd_done),
		.core_stat_i(cs), .full_duplex_i(duplex),
		.scan_out_flush_i(flush), .scan_out_pop_i(pop),
		.scan_out_data_o(so_data), .scan_out_valid_o(so_valid),
		.scan_in_push_i(push), .scan_in_data_i(push_d),
		.scan_in_full_o(sin_full));

	task automatic stop_test();
		// a read that never answered counts as a miss
		num_errors += exp_q.size();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [7:0] stat(input logic f);
		return {1'b1, f, cs.counter_state_flag, 1'b0, cs.tap_state_field};
	endfunction

	task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
		exp_q.push_back(exp);
		name_q.push_back($sformatf("reg%0d", sel));
		host.xfer(1'b1, sel, 8'h00, 1'b0);
	endtask

	task automatic wr(input logic [2:0] sel, input logic [7:0] d);
		host.xfer(1'b0, sel, d, 1'b0);
	endtask

	task automatic pulse(input int k);
		case (k)
			0: cmd_done <= 1'b1;
			1: pop <= 1'b1;
			default: push <= 1'b1;
		endcase
		@(posedge clk_i);
		cmd_done <= 1'b0;
		pop <= 1'b0;
		push <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// check an access is held, then clear its cause unless k is 4
	task automatic held(input int k);
		repeat (20) @(posedge clk_i);
		chk("grant", {7'h00, grant}, 8'h00);
		if (k < 3)
			pulse(k);
		else
			flush <= 1'b0;
	endtask

	always @(posedge clk_i) begin
		hi_cnt <= h_stb_n ? hi_cnt + 1 : 0;
		wr_cnt <= h_rnw ? 0 : wr_cnt + 1;
		if (sreset === 1'b1)
			sr_cnt <= sr_cnt + 1;
		if (h_oe | d_oe)
			last <= bus;
		if (hi_cnt > 6 || wr_cnt > 6)
			chk("oe", {7'h00, d_oe}, 8'h00);
		if (h_done === 1'b1 && exp_q.size() > 0)
			chk(name_q.pop_front(), h_rdata, exp_q.pop_front());
		if (h_tout === 1'b1) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		resetn_i = 1'b0;
		cmd_done = 1'b0;
		pop = 1'b0;
		push = 1'b0;
		flush = 1'b0;
		duplex = 1'b0;
		push_d = 8'h00;
		ce = 1'b1;
		v = 8'($urandom(78381));
		cs = shp_core_stat_t'(5'($urandom));
		for (int i = 0; i < 6; i++)
			b[i] = 8'($urandom);
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		chk("grant", {7'h00, grant}, 8'h01);
		for (int i = 0; i < 8; i++)
			if (i != 5) begin
				v = (i == 1) ? 8'h80 : 8'h00;
				rd(3'(i), i == 2 ? stat(1'b0) : v);
			end
		$display("test reset values done");
		for (int i = 0; i < 8; i++)
			if (wmask[i] != 8'h00) begin
				v = 8'($urandom) & wmask[i];
				wr(3'(i), v);
				rd(3'(i), v);
			end
		chk("cfg", cfg.manual, v);
		man = v;
		wr(3'h2, 8'hFF);
		rd(3'h2, stat(1'b0));
		wr(3'h5, ~b[0]);
		push_d <= b[0];
		fork
			rd(3'h5, b[0]);
			held(2);
		join
		$display("test register access done");
		for (int i = 0; i < 4; i++)
			wr(3'h4, b[i]);
		rd(3'h2, stat(1'b1));
		fork
			wr(3'h4, b[4]);
			held(1);
		join
		for (int i = 1; i < 5; i++) begin
			chk("head", so_data, b[i]);
			pulse(1);
		end
		chk("valid", {7'h00, so_valid}, 8'h00);
		flush <= 1'b1;
		fork
			wr(3'h4, b[5]);
			held(3);
		join
		rd(3'h4, b[5]);
		pulse(1);
		$display("test scan-out hold done");
		wr(3'h3, 8'h01);
		rd(3'h3, 8'h01);
		wr(3'h7, 8'h05);
		fork
			wr(3'h0, 8'h22);
			held(0);
		join
		rd(3'h0, 8'h22);
		rd(3'h3, 8'h00);
		rd(3'h7, man);
		wr(3'h3, 8'h01);
		fork
			wr(3'h3, 8'h02);
			held(0);
		join
		rd(3'h3, 8'h02);
		wr(3'h3, 8'h80);
		chk("sreset", 8'(sr_cnt), 8'h01);
		rd(3'h3, 8'h00);
		$display("test busy command done");
		// a push while the clock enable is low must not land
		ce <= 1'b0;
		push_d <= b[5];
		pulse(2);
		ce <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			push_d <= b[i];
			pulse(2);
		end
		chk("full", {7'h00, sin_full}, 8'h01);
		for (int i = 0; i < 4; i++)
			rd(3'h5, b[i]);
		chk("full", {7'h00, sin_full}, 8'h00);
		$display("test scan-in fill done");
		wr(3'h1, 8'h81);
		duplex <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(3'h4, b[i]);
			pulse(1);
		end
		fork
			host.xfer(1'b0, 3'h4, b[4], 1'b1);
			held(4);
		join
		rd(3'h4, b[3]);
		push_d <= b[5];
		pulse(2);
		rd(3'h5, b[5]);
		wr(3'h4, b[4]);
		rd(3'h4, b[4]);
		duplex <= 1'b0;
		pulse(1);
		$display("test duplex lead done");
		stop_test();
	end
endmodule
